// ===== rtl/irm_pkg.sv
// irm_pkg: constants, state and config types for the infrared serial modulator
// assumes a 100 MHz system clock and a uart-style bit stream on the serial side
// Summary of operation
// [RL1] pulse mode runs at serial rates up to 115k baud, bit time from the programmed rate.
// [RL2] every word sent starts with a zero start bit, then the rest of the word in order.
// [RL3] in pulse mode a zero bit is one infrared pulse at the start of its bit period.
// [RL4] in pulse mode a one bit gives no pulse anywhere in its bit period.
// [RL5] carrier-keyed mode runs at serial rates up to 19.2k baud.
// [RL6] in carrier-keyed mode a zero bit is a 500kHz carrier for the whole bit period.
// [RL7] in carrier-keyed mode a one bit leaves the output idle for the whole bit period.
// [RL8] receive decodes with the same scheme: pulse or carrier seen in a bit is zero, else one.
package irm_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int PULSE_MAX_BAUD = 115_200;
	localparam int CARRIER_MAX_BAUD = 19_200;
	localparam int CARRIER_HZ = 500_000;
	// half period of the carrier, in clock cycles
	localparam int CARRIER_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
	// pulse length: 3/16 of the bit time, a classic infrared pulse width
	localparam int PULSE_NUM = 3;
	localparam int PULSE_DEN = 16;
	localparam int DIV_W = 16;
	// least divisors, in clock cycles per bit, for each mode
	localparam logic [DIV_W-1:0] PULSE_MIN_DIV =
		DIV_W'((CLK_HZ + PULSE_MAX_BAUD - 1) / PULSE_MAX_BAUD);
	localparam logic [DIV_W-1:0] CARRIER_MIN_DIV =
		DIV_W'((CLK_HZ + CARRIER_MAX_BAUD - 1) / CARRIER_MAX_BAUD);
	// carrier edges inside a bit period that count as a burst
	localparam logic [3:0] CARRIER_EDGES_MIN = 4'h3;

	typedef enum logic [1:0] {
		IRM_IDLE = 2'b00,
		IRM_START = 2'b01,
		IRM_DATA = 2'b11,
		IRM_STOP = 2'b10
	} irm_state_e;

	typedef struct packed {
		logic carrier_keyed_infrared_mode;
		logic [DIV_W-1:0] bit_div;
	} irm_cfg_s;
endpackage

// ===== rtl/irm_bit_timer.sv
// irm_bit_timer: counts clock cycles within one serial bit period
// assumes div of at least two; restart realigns to a new bit
`timescale 1ns/100ps
module irm_bit_timer
	import irm_pkg::*;
#(
	parameter int W = DIV_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control
	input wire logic restart,
	input wire logic [W-1:0] div,
	// status
	output logic [W-1:0] count,
	output logic bit_end
);
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count + W'(1);
		if (restart || count >= div - W'(1)) begin
			next_count = '0;
		end
	end

	assign bit_end = (count >= div - W'(1)) && !restart;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (ce) begin
			count <= next_count;
		end
	end
endmodule // irm_bit_timer

// ===== rtl/irm_codec.sv
// irm_codec: infrared modulator and demodulator for a uart-style serial port
// assumes the serial side holds tx_data until tx_ready, and a transceiver on the pins
`timescale 1ns/100ps
module irm_codec
	import irm_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// configuration
	input wire irm_cfg_s cfg,
	// transmit word
	input wire logic tx_valid,
	input wire logic [DATA_W-1:0] tx_data,
	output logic tx_ready,
	// received word
	output logic rx_valid,
	output logic [DATA_W-1:0] rx_data,
	output logic rx_frame_err,
	// transceiver pins
	output logic infrared_transmit_out,
	output logic infrared_mode_select,
	input wire logic infrared_receive_in
);
	logic mode_ask;
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] pulse_len;

	// [RL1] pulse rate limit
	// [RL5] carrier rate limit
	always_comb begin
		mode_ask = cfg.carrier_keyed_infrared_mode;
		div = cfg.bit_div;
		if (!mode_ask && div < PULSE_MIN_DIV) begin
			div = PULSE_MIN_DIV;
		end
		if (mode_ask && div < CARRIER_MIN_DIV) begin
			div = CARRIER_MIN_DIV;
		end
		pulse_len = DIV_W'((32'(div) * PULSE_NUM) / PULSE_DEN);
	end

	// free-running carrier; reset state is fine since it only gates zeros
	logic [7:0] car_cnt, next_car_cnt;
	logic car, next_car;
	always_comb begin
		next_car_cnt = car_cnt + 8'h01;
		next_car = car;
		if (car_cnt >= 8'(CARRIER_HALF_CYC - 1)) begin
			next_car_cnt = 8'h00;
			next_car = !car;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			car_cnt <= 8'h00;
			car <= 1'b0;
		end else if (ce) begin
			car_cnt <= next_car_cnt;
			car <= next_car;
		end
	end

	// transmit
	irm_state_e tx_st, next_tx_st;
	logic [DATA_W-1:0] tx_sh, next_tx_sh;
	logic [3:0] tx_n, next_tx_n;
	logic tx_bit, next_tx_bit;
	logic next_tx_ready, next_ir_out;
	logic tx_restart, tx_end;
	logic [DIV_W-1:0] tx_cnt;

	irm_bit_timer #(.W(DIV_W)) u_tx_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.restart(tx_restart),
		.div(div),
		.count(tx_cnt),
		.bit_end(tx_end)
	);

	always_comb begin
		next_tx_st = tx_st;
		next_tx_sh = tx_sh;
		next_tx_n = tx_n;
		next_tx_bit = tx_bit;
		tx_restart = 1'b0;
		case (tx_st)
			IRM_IDLE: begin
				next_tx_bit = 1'b1;
				tx_restart = 1'b1;
				// [RL2] start bit zero
				if (tx_valid) begin
					next_tx_sh = tx_data;
					next_tx_bit = 1'b0;
					next_tx_n = 4'h0;
					next_tx_st = IRM_START;
				end
			end
			IRM_START: begin
				if (tx_end) begin
					next_tx_bit = tx_sh[0];
					next_tx_sh = tx_sh >> 1;
					next_tx_st = IRM_DATA;
				end
			end
			IRM_DATA: begin
				// [RL2] then lsb first
				if (tx_end) begin
					next_tx_n = tx_n + 4'h1;
					if (tx_n == 4'(DATA_W - 1)) begin
						next_tx_bit = 1'b1;
						next_tx_st = IRM_STOP;
					end else begin
						next_tx_bit = tx_sh[0];
						next_tx_sh = tx_sh >> 1;
					end
				end
			end
			IRM_STOP: begin
				if (tx_end) begin
					next_tx_st = IRM_IDLE;
				end
			end
			default: next_tx_st = IRM_IDLE;
		endcase
		next_tx_ready = (next_tx_st == IRM_IDLE) && !(tx_st == IRM_IDLE && tx_valid);
		next_ir_out = 1'b0;
		if (tx_st != IRM_IDLE && !tx_bit) begin
			// [RL6] carrier whole zero bit
			// [RL3] one pulse at bit start
			next_ir_out = mode_ask ? car : (tx_cnt < pulse_len);
		end
		// [RL4] no pulse for one
		// [RL7] idle for one
		if (tx_bit) begin
			next_ir_out = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st <= IRM_IDLE;
			tx_sh <= '0;
			tx_n <= 4'h0;
			tx_bit <= 1'b1;
			tx_ready <= 1'b0;
			infrared_transmit_out <= 1'b0;
			infrared_mode_select <= 1'b0;
		end else if (ce) begin
			tx_st <= next_tx_st;
			tx_sh <= next_tx_sh;
			tx_n <= next_tx_n;
			tx_bit <= next_tx_bit;
			tx_ready <= next_tx_ready;
			infrared_transmit_out <= next_ir_out;
			infrared_mode_select <= mode_ask;
		end
	end

	// receive pin synchroniser: second and third stages must agree
	logic [2:0] rx_sync;
	logic rx_lvl, next_rx_lvl, rx_prev;
	always_comb begin
		next_rx_lvl = rx_lvl;
		if (rx_sync[1] == rx_sync[2]) begin
			next_rx_lvl = rx_sync[2];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_sync <= 3'b000;
			rx_lvl <= 1'b0;
			rx_prev <= 1'b0;
		end else if (ce) begin
			rx_sync <= {rx_sync[1:0], infrared_receive_in};
			rx_lvl <= next_rx_lvl;
			rx_prev <= rx_lvl;
		end
	end
	logic rx_rise;
	assign rx_rise = rx_lvl && !rx_prev;

	irm_state_e rx_st, next_rx_st;
	logic [DATA_W-1:0] rx_sh, next_rx_sh;
	logic [3:0] rx_n, next_rx_n;
	logic [3:0] rx_edges, next_rx_edges;
	logic rx_seen, next_rx_valid, next_rx_err;
	logic [DATA_W-1:0] next_rx_data;
	logic rx_restart, rx_end;
	logic [DIV_W-1:0] rx_cnt;

	irm_bit_timer #(.W(DIV_W)) u_rx_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.restart(rx_restart),
		.div(div),
		.count(rx_cnt),
		.bit_end(rx_end)
	);

	// [RL8] zero when pulse or burst seen
	always_comb begin
		next_rx_st = rx_st;
		next_rx_sh = rx_sh;
		next_rx_n = rx_n;
		next_rx_edges = rx_edges;
		next_rx_valid = 1'b0;
		next_rx_err = 1'b0;
		next_rx_data = rx_data;
		rx_restart = 1'b0;
		if (rx_rise && rx_edges != 4'hF) begin
			next_rx_edges = rx_edges + 4'h1;
		end
		// a lone glitch must not pass as a carrier burst
		rx_seen = mode_ask ? (next_rx_edges >= CARRIER_EDGES_MIN) : (next_rx_edges != 4'h0);
		if (rx_end) begin
			next_rx_edges = 4'h0;
		end
		case (rx_st)
			IRM_IDLE: begin
				rx_restart = 1'b1;
				next_rx_edges = 4'h0;
				if (rx_rise) begin
					next_rx_edges = 4'h1;
					next_rx_n = 4'h0;
					next_rx_st = IRM_START;
				end
			end
			IRM_START: begin
				// pulse windows straddle each bit start, so a pulse never sits on a window edge
				if (!mode_ask && rx_cnt >= (div >> 1)) begin
					rx_restart = 1'b1;
					next_rx_edges = 4'h0;
					next_rx_st = rx_seen ? IRM_DATA : IRM_IDLE;
				end
				// a burst fills its whole bit, so carrier windows follow the bit itself
				if (mode_ask && rx_end) begin
					next_rx_st = rx_seen ? IRM_DATA : IRM_IDLE;
				end
			end
			IRM_DATA: begin
				if (rx_end) begin
					next_rx_sh = {!rx_seen, rx_sh[DATA_W-1:1]};
					next_rx_n = rx_n + 4'h1;
					if (rx_n == 4'(DATA_W - 1)) begin
						next_rx_st = IRM_STOP;
					end
				end
			end
			IRM_STOP: begin
				if (rx_end) begin
					next_rx_valid = 1'b1;
					next_rx_err = rx_seen;
					next_rx_data = rx_sh;
					next_rx_st = IRM_IDLE;
				end
			end
			default: next_rx_st = IRM_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_st <= IRM_IDLE;
			rx_sh <= '0;
			rx_n <= 4'h0;
			rx_edges <= 4'h0;
			rx_valid <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_data <= '0;
		end else if (ce) begin
			rx_st <= next_rx_st;
			rx_sh <= next_rx_sh;
			rx_n <= next_rx_n;
			rx_edges <= next_rx_edges;
			rx_valid <= next_rx_valid;
			rx_frame_err <= next_rx_err;
			rx_data <= next_rx_data;
		end
	end
endmodule // irm_codec

// ===== test/irm_xcvr_model.sv
// irm_xcvr_model: optical loopback transceiver on the codec pins
// assumes one clock; light reaches the detector LAT cycles later
`timescale 1ns/100ps
module irm_xcvr_model #(
	parameter int LAT = 3
) (
	// clock
	input wire logic clk,
	// codec pins
	input wire logic infrared_transmit_out,
	input wire logic infrared_mode_select,
	output logic infrared_receive_in
);
	// dark reads 0: the detector rests low with no light
	logic [LAT-1:0] path = '0;
	always @(posedge clk) path <= {path[LAT-2:0], infrared_transmit_out};
	assign infrared_receive_in = path[LAT-1];
endmodule // irm_xcvr_model

// ===== test/irm_codec_monitor.sv
// irm_codec_monitor: port checks for the infrared codec
// assumes one clock domain; the run counters pause while ce is low
`timescale 1ns/100ps
module irm_codec_monitor
	import irm_pkg::*;
#(
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire irm_cfg_s cfg,
	// serial side
	input wire logic tx_valid,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [DATA_W-1:0] rx_data,
	input wire logic rx_frame_err,
	// pins
	input wire logic infrared_transmit_out,
	input wire logic infrared_mode_select,
	input wire logic infrared_receive_in
);
	int hi;
	int busy;
	int eff;
	logic ck;
	assign ck = cfg.carrier_keyed_infrared_mode;
	assign eff = (cfg.bit_div < PULSE_MIN_DIV) ? int'(PULSE_MIN_DIV) : int'(cfg.bit_div);
	// busy starts large so the first ready after reset passes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi <= 0;
			busy <= 1 << 20;
		end else if (ce) begin
			hi <= infrared_transmit_out ? hi + 1 : 0;
			busy <= tx_ready ? 0 : busy + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	take_drop_a: assert property (tx_valid && tx_ready |=> !tx_ready)
		else $error("ready stayed high");
	start_lit_a: assert property (!ck && tx_valid && tx_ready |->
		##2 infrared_transmit_out)
		else $error("start bit dark");
	// carrier phase is free-running, so light may wait up to one half period
	start_burst_a: assert property (ck && tx_valid && tx_ready |->
		##[2:102] infrared_transmit_out)
		else $error("start burst dark");
	idle_dark_a: assert property (tx_ready |-> !infrared_transmit_out)
		else $error("light while idle");
	pulse_len_a: assert property (!ck |-> hi <= eff * 3 / 16)
		else $error("pulse too long");
	pulse_once_a: assert property (!ck && $fell(infrared_transmit_out) |=>
		!infrared_transmit_out [*8])
		else $error("second pulse in bit");
	carrier_half_a: assert property (ck |-> hi <= CARRIER_HALF_CYC)
		else $error("carrier half too long");
	rate_cap_a: assert property ($rose(tx_ready) |->
		busy >= 9 * (ck ? CARRIER_MIN_DIV : PULSE_MIN_DIV))
		else $error("frame too fast");
	rx_pulse_a: assert property (rx_valid |=> !rx_valid)
		else $error("rx valid held");
	err_with_a: assert property (rx_frame_err |-> rx_valid)
		else $error("error without word");
endmodule // irm_codec_monitor
bind irm_codec irm_codec_monitor #(.DATA_W(DATA_W)) i_irm_codec_monitor (.clk(clk), .rst(rst),
	.ce(ce), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_err(rx_frame_err),
	.infrared_transmit_out(infrared_transmit_out),
	.infrared_mode_select(infrared_mode_select), .infrared_receive_in(infrared_receive_in));

// ===== test/irm_codec_test.sv
// irm_codec_test: loopback bench, queue model of sent words
// assumes the transceiver model echoes the emitter to the detector
`timescale 1ns/100ps
module irm_codec_test
	import irm_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	irm_cfg_s cfg = '{1'b0, 16'h0365};
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] rx_data;
	logic tx_ready, rx_valid, rx_frame_err, ir_tx, ir_sel, ir_rx;
	logic ir_q = 1'b0;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 61;
	int n_rise = 0;
	int want = 0;
	int base;
	logic [7:0] exp_q[$];
	always #5 clk = ~clk;
	irm_codec i_irm_codec (.clk(clk), .rst(rst), .ce(ce), .cfg(cfg), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_frame_err(rx_frame_err), .infrared_transmit_out(ir_tx),
		.infrared_mode_select(ir_sel), .infrared_receive_in(ir_rx));
	irm_xcvr_model i_irm_xcvr_model (.clk(clk), .infrared_transmit_out(ir_tx),
		.infrared_mode_select(ir_sel), .infrared_receive_in(ir_rx));
	task automatic print_verdict();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	always @(posedge clk) begin
		ir_q <= ir_tx;
		if (ir_tx === 1'b1 && ir_q === 1'b0) n_rise <= n_rise + 1;
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) check(1'b0, "stray word");
			else check(rx_data === exp_q.pop_front() && rx_frame_err === 1'b0, "rx word");
		end
	end
	// leaves tx_valid up so a back-to-back word waits while busy
	task automatic send(input logic [7:0] d);
		int k;
		tx_valid <= 1'b1;
		tx_data <= d;
		for (k = 0; k < 60000; k++) begin
			@(posedge clk);
			if (tx_ready === 1'b1) break;
		end
		check(k < 60000, "not taken");
		if (k >= 60000) print_verdict();
		exp_q.push_back(d);
		want += 9 - $countones(d);
	endtask
	task automatic drain(input string name);
		int k;
		tx_valid <= 1'b0;
		for (k = 0; k < 60000 && (exp_q.size() != 0 || tx_ready !== 1'b1); k++) @(posedge clk);
		check(k < 60000, "rx timeout");
		if (k >= 60000) print_verdict();
		$display("test %s done, fails %0d", name, n_fail);
	endtask
	initial begin
		int k;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check(ir_sel === 1'b0 && tx_ready === 1'b1, "idle after reset");
		base = n_rise;
		send(8'h00);
		send(8'hFF);
		send(8'($random(seed)));
		drain("pulse");
		check(n_rise - base === want, "pulse count");
		// below the floor, the divisor is raised to the fastest legal rate
		cfg <= '{1'b0, 16'h000A};
		@(posedge clk);
		send(8'($random(seed)));
		// drop valid at once so the word is not taken twice when ready returns
		tx_valid <= 1'b0;
		// 16 edges with ce low must stretch the frame by exactly that much
		repeat (20) @(posedge clk);
		ce <= 1'b0;
		repeat (16) @(posedge clk);
		check(ir_tx === 1'b1 && tx_ready === 1'b0, "frozen pulse");
		ce <= 1'b1;
		for (k = 36; k < 60000 && tx_ready !== 1'b1; k++) @(posedge clk);
		// one more edge: ready is seen the edge after it is set
		check(k == 10 * int'(PULSE_MIN_DIV) + 17, "frame length");
		drain("clamp");
		cfg <= '{1'b1, 16'h1459};
		@(posedge clk);
		send(8'h5A);
		@(posedge clk);
		check(ir_sel === 1'b1, "mode pin");
		drain("carrier");
		print_verdict();
	end
endmodule // irm_codec_test
